// File: dbic_pkg.sv
// Purpose: Shared constants and state type for the doorbell interrupt condition block
// Assumes: 50 MHz sys_clk, 12-bit register byte address, 32-bit register data
// Notes:   Doorbell status/clear offsets follow the peripheral memory map

package dbic_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_DB    = 4;
    localparam int DB_BITS   = 16;
    localparam int NUM_PORTS = 4;
    localparam int NUM_CORES = 4;
    localparam int CNT_W     = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] DB_STAT_BASE = 12'h200;
    localparam logic [11:0] DB_CLR_OFS   = 12'h008;
    localparam logic [11:0] DB_STRIDE    = 12'h010;
    localparam logic [11:0] MSG_STAT     = 12'h240;
    localparam logic [11:0] MSG_CLR      = 12'h248;
    localparam logic [11:0] ERR_STAT     = 12'h250;
    localparam logic [11:0] ERR_CLR      = 12'h258;
    localparam logic [11:0] CRIT_STAT    = 12'h260;
    localparam logic [11:0] CRIT_CLR     = 12'h268;
    localparam logic [11:0] LINK_CFG     = 12'h270;
    localparam logic [11:0] DMA_CNT      = 12'h274;
    localparam logic [11:0] ROUTE_BASE   = 12'h280;
    localparam logic [11:0] ROUTE_STRIDE = 12'h004;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          INFO_BIT_LSB   = 0;
    localparam int          INFO_DB_LSB    = 4;
    localparam logic [15:0] INFO_RSVD_MASK = 16'hFFC0;
    localparam int          CFG_THRESH_LSB = 0;
    localparam int          CFG_PW_EN_BIT  = 8;
    localparam int          CFG_MSG_CORE   = 12;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] THRESH_RST     = 8'h10;
    localparam logic [2:0] RST_SYM_COUNT  = 3'h4;
    localparam logic [1:0] MSG_CORE_RST   = 2'h0;

    typedef struct packed {
        logic [63:0]  db_pend;
        logic         msg_pend;
        logic [7:0]   dma_outst;
        logic [127:0] route;
        logic [7:0]   err_thresh;
        logic         pw_en;
        logic [1:0]   msg_core;
        logic [31:0]  err_cnt;
        logic [2:0]   rst_seq;
        logic         db_resp_valid;
        logic         db_resp_err;
        logic         desc_valid;
        logic         desc_sop;
        logic         desc_eop;
        logic         desc_last_in_queue;
        logic [15:0]  desc_len;
        logic [31:0]  desc_buf_addr;
        logic [31:0]  desc_link_addr;
        logic [31:0]  prev_desc_addr;
        logic [31:0]  rdata;
        logic         rvalid;
        logic         pw_valid;
        logic [1:0]   pw_port;
        logic [3:0]   link_recover;
        logic         link_reset;
        logic         dma_wr_with_resp;
        logic [3:0]   int_service;
        logic         int_error;
        logic         int_critical;
    } dbic_state_s;

    localparam dbic_state_s STATE_RST = '{
        err_thresh       : THRESH_RST,
        msg_core         : MSG_CORE_RST,
        dma_wr_with_resp : 1'b1,
        default          : '0
    };

endpackage

// File: dbic_cond_bits.sv
// Purpose: Sticky condition status bits with write-one clear
// Assumes: set and clear pulses are on sys_clk
// Notes:   A set in the same cycle as a write-one clear wins; soft_clr wins over a set

`timescale 1ns/1ns

module dbic_cond_bits #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Condition events
    input  wire logic         soft_clr,
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    // Status
    output logic      [W-1:0] stat
);

    typedef struct packed {
        logic [W-1:0] stat;
    } dbic_cond_s;

    dbic_cond_s s_r;
    dbic_cond_s s_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (soft_clr) begin
            s_nxt.stat = '0;
        end else begin
            s_nxt.stat = (s_r.stat & ~clr_bits) | set_bits;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign stat = s_r.stat;

endmodule

// File: dbic_top.sv
// Purpose: Doorbell, message and link error interrupt conditions
// Assumes: Link and DMA event inputs are on sys_clk; register port is the CPU memory map
// Notes:   Servicing interrupts wait for all DMA write responses

`timescale 1ns/1ns

module dbic_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // CPU register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_rvalid,
    // Inbound doorbell packets
    input  wire logic        db_valid,
    input  wire logic [15:0] db_info,
    output logic             db_resp_valid,
    output logic             db_resp_err,
    // Inbound message packets
    input  wire logic        msg_valid,
    input  wire logic        msg_sop,
    input  wire logic        msg_eop,
    input  wire logic        msg_eoq,
    input  wire logic [15:0] msg_len,
    input  wire logic [31:0] msg_buf_addr,
    input  wire logic [31:0] msg_desc_addr,
    // Descriptor out
    output logic             desc_valid,
    output logic             desc_sop,
    output logic             desc_eop,
    output logic             desc_last_in_queue,
    output logic      [15:0] desc_len,
    output logic      [31:0] desc_buf_addr,
    output logic      [31:0] desc_link_addr,
    // DMA write tracking
    input  wire logic        dma_wr_issue,
    input  wire logic        dma_wr_resp,
    output logic             dma_wr_with_resp,
    // Link events
    input  wire logic [3:0]  link_err,
    input  wire logic        ctl_sym_valid,
    input  wire logic        ctl_sym_is_reset,
    output logic      [3:0]  link_recover,
    output logic             link_reset,
    output logic             pw_valid,
    output logic      [1:0]  pw_port,
    // CPU interrupts
    output logic      [3:0]  int_service,
    output logic             int_error,
    output logic             int_critical
);

    dbic_pkg::dbic_state_s s_r;
    dbic_pkg::dbic_state_s s_nxt;

    logic [63:0] db_set;
    logic [63:0] db_clr;
    logic [63:0] db_stat;
    logic        msg_set;
    logic        msg_clr;
    logic        msg_stat;
    logic [3:0]  err_set;
    logic [3:0]  err_clr;
    logic [3:0]  err_stat;
    logic        crit_set;
    logic        crit_clr;
    logic        crit_stat;
    logic        soft_rst;

    // ------------------------------------------------------------
    // Condition status registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < dbic_pkg::NUM_DB; g++) begin : g_db
            dbic_cond_bits #(
                .W (dbic_pkg::DB_BITS)
            ) u_db (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .soft_clr (soft_rst),
                .set_bits (db_set[g*16 +: 16]),
                .clr_bits (db_clr[g*16 +: 16]),
                .stat     (db_stat[g*16 +: 16])
            );
        end
    endgenerate

    dbic_cond_bits #(
        .W (1)
    ) u_msg (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .soft_clr (soft_rst),
        .set_bits (msg_set),
        .clr_bits (msg_clr),
        .stat     (msg_stat)
    );

    dbic_cond_bits #(
        .W (dbic_pkg::NUM_PORTS)
    ) u_err (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .soft_clr (soft_rst),
        .set_bits (err_set),
        .clr_bits (err_clr),
        .stat     (err_stat)
    );

    dbic_cond_bits #(
        .W (1)
    ) u_crit (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .soft_clr (1'b0),
        .set_bits (crit_set),
        .clr_bits (crit_clr),
        .stat     (crit_stat)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        outst_zero;
        logic [63:0] new_db;
        logic [1:0]  core;
        logic [31:0] rd;
        logic [11:0] a;
        logic [7:0]  cnt;

        outst_zero = 1'b0;
        new_db     = '0;
        core       = '0;
        rd         = '0;
        a          = '0;
        cnt        = '0;
        s_nxt      = s_r;
        db_clr     = '0;
        msg_clr    = 1'b0;
        err_clr    = '0;
        crit_clr   = 1'b0;
        err_set    = '0;
        soft_rst   = 1'b0;
        crit_set   = 1'b0;

        // One-cycle pulses fall back
        s_nxt.db_resp_valid = 1'b0;
        s_nxt.desc_valid    = 1'b0;
        s_nxt.rvalid        = 1'b0;
        s_nxt.pw_valid      = 1'b0;
        s_nxt.link_reset    = 1'b0;

        // Link-level errors retrain the port on their own
        s_nxt.link_recover = link_err;

        // Outstanding DMA write counter
        if (dma_wr_issue && !dma_wr_resp) begin
            s_nxt.dma_outst = s_r.dma_outst + 8'h01;
        end else if (dma_wr_resp && !dma_wr_issue && s_r.dma_outst != 8'h00) begin
            s_nxt.dma_outst = s_r.dma_outst - 8'h01;
        end
        outst_zero = (s_r.dma_outst == 8'h00) && !dma_wr_issue;
        s_nxt.dma_wr_with_resp = 1'b1;

        // Doorbell packet decode
        if (db_valid) begin
            s_nxt.db_resp_valid = 1'b1;
            if ((db_info & dbic_pkg::INFO_RSVD_MASK) != 16'h0000) begin
                s_nxt.db_resp_err = 1'b1;
            end else begin
                s_nxt.db_resp_err = 1'b0;
                new_db[{db_info[dbic_pkg::INFO_DB_LSB +: 2],
                        db_info[dbic_pkg::INFO_BIT_LSB +: 4]}] = 1'b1;
            end
        end

        // Pending data conditions released once DMA is quiet
        if (outst_zero) begin
            db_set         = s_r.db_pend | new_db;
            s_nxt.db_pend  = '0;
            msg_set        = s_r.msg_pend | (msg_valid && msg_eop);
            s_nxt.msg_pend = 1'b0;
        end else begin
            db_set         = '0;
            s_nxt.db_pend  = s_r.db_pend | new_db;
            msg_set        = 1'b0;
            s_nxt.msg_pend = s_r.msg_pend | (msg_valid && msg_eop);
        end

        // Message descriptor build and link
        if (msg_valid) begin
            s_nxt.desc_valid         = 1'b1;
            s_nxt.desc_sop           = msg_sop;
            s_nxt.desc_eop           = msg_eop;
            s_nxt.desc_last_in_queue = msg_eoq;
            s_nxt.desc_len           = msg_len;
            s_nxt.desc_buf_addr      = msg_buf_addr;
            s_nxt.desc_link_addr     = s_r.prev_desc_addr;
            s_nxt.prev_desc_addr     = msg_desc_addr;
        end

        // Per-port link error counting
        for (int p = 0; p < dbic_pkg::NUM_PORTS; p++) begin
            cnt = s_r.err_cnt[p*8 +: 8];
            if (link_err[p]) begin
                cnt = cnt + 8'h01;
            end
            if (cnt > s_r.err_thresh) begin
                cnt = 8'h00;
                if (s_r.pw_en) begin
                    s_nxt.pw_valid = 1'b1;
                    s_nxt.pw_port  = 2'(p);
                end else begin
                    err_set[p] = 1'b1;
                end
            end
            s_nxt.err_cnt[p*8 +: 8] = cnt;
        end

        // Consecutive reset control symbols
        if (ctl_sym_valid) begin
            if (!ctl_sym_is_reset) begin
                s_nxt.rst_seq = 3'h0;
            end else if (s_r.rst_seq == dbic_pkg::RST_SYM_COUNT - 3'h1) begin
                soft_rst = 1'b1;
                crit_set = 1'b1;
            end else begin
                s_nxt.rst_seq = s_r.rst_seq + 3'h1;
            end
        end

        // Register writes
        if (reg_wr) begin
            for (int k = 0; k < dbic_pkg::NUM_DB; k++) begin
                a = dbic_pkg::DB_STAT_BASE + 12'(k) * dbic_pkg::DB_STRIDE + dbic_pkg::DB_CLR_OFS;
                if (reg_addr == a) begin
                    db_clr[k*16 +: 16] = reg_wdata[15:0];
                end
                a = dbic_pkg::ROUTE_BASE + 12'(k) * dbic_pkg::ROUTE_STRIDE;
                if (reg_addr == a) begin
                    s_nxt.route[k*32 +: 32] = reg_wdata;
                end
            end
            if (reg_addr == dbic_pkg::MSG_CLR) begin
                msg_clr = reg_wdata[0];
            end
            if (reg_addr == dbic_pkg::ERR_CLR) begin
                err_clr = reg_wdata[3:0];
            end
            if (reg_addr == dbic_pkg::CRIT_CLR) begin
                crit_clr = reg_wdata[0];
            end
            if (reg_addr == dbic_pkg::LINK_CFG) begin
                s_nxt.err_thresh = reg_wdata[dbic_pkg::CFG_THRESH_LSB +: 8];
                s_nxt.pw_en      = reg_wdata[dbic_pkg::CFG_PW_EN_BIT];
                s_nxt.msg_core   = reg_wdata[dbic_pkg::CFG_MSG_CORE +: 2];
            end
        end

        // Register reads; clear registers read zero
        if (reg_rd) begin
            for (int k = 0; k < dbic_pkg::NUM_DB; k++) begin
                a = dbic_pkg::DB_STAT_BASE + 12'(k) * dbic_pkg::DB_STRIDE;
                if (reg_addr == a) begin
                    rd = {16'h0000, db_stat[k*16 +: 16]};
                end
                a = dbic_pkg::ROUTE_BASE + 12'(k) * dbic_pkg::ROUTE_STRIDE;
                if (reg_addr == a) begin
                    rd = s_r.route[k*32 +: 32];
                end
            end
            if (reg_addr == dbic_pkg::MSG_STAT) begin
                rd = {31'h00000000, msg_stat};
            end
            if (reg_addr == dbic_pkg::ERR_STAT) begin
                rd = {28'h0000000, err_stat};
            end
            if (reg_addr == dbic_pkg::CRIT_STAT) begin
                rd = {31'h00000000, crit_stat};
            end
            if (reg_addr == dbic_pkg::LINK_CFG) begin
                rd = {18'h00000, s_r.msg_core, 3'h0, s_r.pw_en, s_r.err_thresh};
            end
            if (reg_addr == dbic_pkg::DMA_CNT) begin
                rd = {24'h000000, s_r.dma_outst};
            end
            s_nxt.rdata  = rd;
            s_nxt.rvalid = 1'b1;
        end

        // Interrupt routing to cores
        s_nxt.int_service = '0;
        for (int b = 0; b < 64; b++) begin
            core = s_r.route[b*2 +: 2];
            if (db_stat[b]) begin
                s_nxt.int_service[core] = 1'b1;
            end
        end
        if (msg_stat) begin
            s_nxt.int_service[s_r.msg_core] = 1'b1;
        end
        s_nxt.int_error    = |err_stat;
        s_nxt.int_critical = crit_stat;

        // Reset requested over the link
        if (soft_rst) begin
            s_nxt              = dbic_pkg::STATE_RST;
            s_nxt.link_reset   = 1'b1;
            s_nxt.int_critical = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= dbic_pkg::STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata          = s_r.rdata;
    assign reg_rvalid         = s_r.rvalid;
    assign db_resp_valid      = s_r.db_resp_valid;
    assign db_resp_err        = s_r.db_resp_err;
    assign desc_valid         = s_r.desc_valid;
    assign desc_sop           = s_r.desc_sop;
    assign desc_eop           = s_r.desc_eop;
    assign desc_last_in_queue = s_r.desc_last_in_queue;
    assign desc_len           = s_r.desc_len;
    assign desc_buf_addr      = s_r.desc_buf_addr;
    assign desc_link_addr     = s_r.desc_link_addr;
    assign dma_wr_with_resp   = s_r.dma_wr_with_resp;
    assign link_recover       = s_r.link_recover;
    assign link_reset         = s_r.link_reset;
    assign pw_valid           = s_r.pw_valid;
    assign pw_port            = s_r.pw_port;
    assign int_service        = s_r.int_service;
    assign int_error          = s_r.int_error;
    assign int_critical       = s_r.int_critical;

endmodule

// File: dbic_top_chk.sv
// Purpose: Port checker for the doorbell interrupt condition block
// Assumes: One sys_clk domain, rst_n async active low
// Notes:   Helper counters mirror the DMA and reset-symbol tracking
`timescale 1ns/1ns
module dbic_top_chk (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Observed ports
    input wire logic        reg_rd,
    input wire logic        reg_rvalid,
    input wire logic        db_valid,
    input wire logic [15:0] db_info,
    input wire logic        db_resp_valid,
    input wire logic        db_resp_err,
    input wire logic        msg_valid,
    input wire logic        msg_eop,
    input wire logic [15:0] msg_len,
    input wire logic        desc_valid,
    input wire logic        desc_eop,
    input wire logic [15:0] desc_len,
    input wire logic        dma_wr_issue,
    input wire logic        dma_wr_resp,
    input wire logic        dma_wr_with_resp,
    input wire logic [3:0]  link_err,
    input wire logic [3:0]  link_recover,
    input wire logic        ctl_sym_valid,
    input wire logic        ctl_sym_is_reset,
    input wire logic        link_reset,
    input wire logic [3:0]  int_service,
    input wire logic        int_critical
);
    logic [7:0] outst_r;
    logic [2:0] run_r;
    logic       fourth;
    assign fourth = ctl_sym_valid && ctl_sym_is_reset && run_r == 3'h3;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outst_r <= 8'h00;
            run_r   <= 3'h0;
        end else begin
            if (fourth)
                outst_r <= 8'h00;
            else if (dma_wr_issue && !dma_wr_resp)
                outst_r <= outst_r + 8'h01;
            else if (dma_wr_resp && !dma_wr_issue && outst_r != 8'h00)
                outst_r <= outst_r - 8'h01;
            if (ctl_sym_valid)
                run_r <= (ctl_sym_is_reset && !fourth) ? run_r + 3'h1 : 3'h0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_db_resp_next: assert property (db_valid |=> db_resp_valid)
        else $error("doorbell without response");
    a_resp_err_rsvd: assert property (db_valid |=> db_resp_err == (($past(db_info) & 16'hFFC0) != 16'h0))
        else $error("doorbell error flag wrong");
    a_read_answer: assert property (reg_rd |=> reg_rvalid ##1 ($past(reg_rd) || !reg_rvalid))
        else $error("read answer timing wrong");
    a_dma_wr_resp: assert property (dma_wr_with_resp)
        else $error("DMA write without response");
    a_desc_build: assert property (msg_valid |=> desc_valid && desc_len == $past(msg_len) && desc_eop == $past(msg_eop))
        else $error("descriptor not built");
    a_link_recover: assert property (link_err != 4'h0 |=> link_recover == $past(link_err))
        else $error("link error not recovered");
    a_reset_fourth: assert property (fourth |=> link_reset && int_critical)
        else $error("no reset after fourth symbol");
    a_no_early_rst: assert property (link_reset |-> $past(fourth))
        else $error("link reset without four symbols");
    a_dma_hold: assert property (outst_r != 8'h00 && $past(outst_r) != 8'h00 |=> (int_service & ~$past(int_service)) == 4'h0)
        else $error("interrupt while DMA outstanding");
endmodule

// File: dbic_far_end.sv
// Purpose: Remote element model sending doorbells, messages and control symbols
// Assumes: Drives after the falling edge of sys_clk
// Notes:   Idle header fields show the inverse of the last value
`timescale 1ns/1ns
module dbic_far_end (
    // Clock
    input  wire logic        sys_clk,
    // Doorbell
    output logic             db_valid,
    output logic      [15:0] db_info,
    // Message header
    output logic             msg_valid,
    output logic             msg_sop,
    output logic             msg_eop,
    output logic             msg_eoq,
    output logic      [15:0] msg_len,
    output logic      [31:0] msg_buf_addr,
    output logic      [31:0] msg_desc_addr,
    // Control symbols
    output logic             ctl_sym_valid,
    output logic             ctl_sym_is_reset
);
    initial begin
        {db_valid, msg_valid, ctl_sym_valid, ctl_sym_is_reset} = 4'h0;
        {msg_sop, msg_eop, msg_eoq, msg_len, db_info} = '0;
        {msg_buf_addr, msg_desc_addr} = '0;
    end
    task automatic send_db(input logic [15:0] info);
        @(negedge sys_clk);
        db_valid = 1'b1;
        db_info  = info;
        @(negedge sys_clk);
        db_valid = 1'b0;
        db_info  = ~info;
    endtask
    task automatic send_msg(input logic [2:0] flg, input logic [15:0] len, input logic [31:0] ba, da);
        @(negedge sys_clk);
        msg_valid = 1'b1;
        {msg_sop, msg_eop, msg_eoq, msg_len, msg_buf_addr, msg_desc_addr} = {flg, len, ba, da};
        @(negedge sys_clk);
        msg_valid = 1'b0;
        {msg_sop, msg_eop, msg_eoq, msg_len, msg_buf_addr, msg_desc_addr} = ~{flg, len, ba, da};
    endtask
    task automatic send_sym(input logic is_rst);
        @(negedge sys_clk);
        ctl_sym_valid    = 1'b1;
        ctl_sym_is_reset = is_rst;
        @(negedge sys_clk);
        ctl_sym_valid    = 1'b0;
        ctl_sym_is_reset = ~is_rst;
    endtask
endmodule

// File: dbic_tb.sv
// Purpose: Self-checking bench for the doorbell interrupt condition block
// Assumes: Inputs change on the falling edge of sys_clk
// Notes:   Far end model drives doorbell, message and symbol traffic
`timescale 1ns/1ns
module tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr, reg_rd, dma_wr_issue, dma_wr_resp, seen;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, desc_buf_addr, desc_link_addr, msg_buf_addr, msg_desc_addr;
    logic [15:0] db_info, msg_len, desc_len;
    logic [3:0]  link_err, link_recover, int_service;
    logic [1:0]  pw_port;
    logic        reg_rvalid, db_valid, db_resp_valid, db_resp_err, msg_valid, msg_sop, msg_eop, msg_eoq;
    logic        desc_valid, desc_sop, desc_eop, desc_last_in_queue, dma_wr_with_resp, ctl_sym_valid;
    logic        ctl_sym_is_reset, link_reset, pw_valid, int_error, int_critical;
    int          n_mismatch = 0, checks = 0;
    always #10 sys_clk = ~sys_clk;
    dbic_top uut (.*);
    dbic_far_end far (.sys_clk(sys_clk), .db_valid(db_valid), .db_info(db_info), .msg_valid(msg_valid),
        .msg_sop(msg_sop), .msg_eop(msg_eop), .msg_eoq(msg_eoq), .msg_len(msg_len), .msg_buf_addr(msg_buf_addr),
        .msg_desc_addr(msg_desc_addr), .ctl_sym_valid(ctl_sym_valid), .ctl_sym_is_reset(ctl_sym_is_reset));
    function automatic logic [11:0] dbs(input int k);
        return dbic_pkg::DB_STAT_BASE + 12'(k) * dbic_pkg::DB_STRIDE;
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge sys_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge sys_clk);
        reg_rd = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1, "read valid missing");
        chk(reg_rdata, exp, "read data");
    endtask
    task automatic pulse_err(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            link_err = 4'h2;
            @(negedge sys_clk);
            link_err = 4'h0;
        end
    endtask
    task automatic summarize;
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
    initial begin
        {reg_wr, reg_rd, dma_wr_issue, dma_wr_resp, reg_addr, reg_wdata, link_err} = '0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int k = 0; k < 4; k++) wr(dbs(k) + dbic_pkg::DB_CLR_OFS, 32'hFFFF);
        rd(dbs(0), 32'h0);
        rd(dbic_pkg::LINK_CFG, 32'h10);
        rd(12'h3F0, 32'h0);
        rd(dbs(2) + dbic_pkg::DB_CLR_OFS, 32'h0);
        for (int k = 0; k < 4; k++) begin
            far.send_db(16'(k * 16 + k * 5));
            rd(dbs(k), 32'h1 << (k * 5));
            wr(dbs(k) + dbic_pkg::DB_CLR_OFS, ~(32'h1 << (k * 5)) & 32'hFFFF);
            wr(dbs(k) + dbic_pkg::DB_CLR_OFS, 32'h0);
            rd(dbs(k), 32'h1 << (k * 5));
            wr(dbs(k) + dbic_pkg::DB_CLR_OFS, 32'h1 << (k * 5));
            rd(dbs(k), 32'h0);
        end
        wr(dbic_pkg::ROUTE_BASE + 12'h4, 32'h80);
        far.send_db(16'h0013);
        @(negedge sys_clk);
        chk({28'h0, int_service}, 32'h4, "routed core");
        wr(dbs(1) + dbic_pkg::DB_CLR_OFS, 32'h8);
        far.send_db(16'h0040);
        chk({31'h0, db_resp_err}, 32'h1, "reserved info");
        rd(dbs(0), 32'h0);
        repeat (2) begin
            @(negedge sys_clk);
            dma_wr_issue = 1'b1;
        end
        @(negedge sys_clk);
        dma_wr_issue = 1'b0;
        far.send_db(16'h0002);
        rd(dbs(0), 32'h0);
        rd(dbic_pkg::DMA_CNT, 32'h2);
        repeat (2) begin
            @(negedge sys_clk);
            dma_wr_resp = 1'b1;
        end
        @(negedge sys_clk);
        dma_wr_resp = 1'b0;
        @(negedge sys_clk);
        rd(dbs(0), 32'h4);
        wr(dbs(0) + dbic_pkg::DB_CLR_OFS, 32'h4);
        far.send_db(16'h0025);
        fork
            far.send_db(16'h0025);
            wr(dbs(2) + dbic_pkg::DB_CLR_OFS, 32'h20);
        join
        rd(dbs(2), 32'h20);
        wr(dbs(2) + dbic_pkg::DB_CLR_OFS, 32'h20);
        far.send_msg(3'b100, 16'h0040, 32'h1000, 32'hA000);
        chk(desc_link_addr, 32'h0, "first link");
        rd(dbic_pkg::MSG_STAT, 32'h0);
        far.send_msg(3'b011, 16'h0020, 32'h2000, 32'hB000);
        chk(desc_link_addr, 32'hA000, "link address");
        chk({13'h0, desc_last_in_queue, desc_eop, desc_sop, desc_len}, {13'h0, 3'b110, 16'h0020}, "flags");
        chk(desc_buf_addr, 32'h2000, "buffer address");
        @(negedge sys_clk);
        rd(dbic_pkg::MSG_STAT, 32'h1);
        chk({28'h0, int_service}, 32'h1, "message interrupt");
        wr(dbic_pkg::MSG_CLR, 32'h1);
        wr(dbic_pkg::LINK_CFG, 32'h2);
        pulse_err(3);
        @(negedge sys_clk);
        rd(dbic_pkg::ERR_STAT, 32'h2);
        chk({31'h0, int_error}, 32'h1, "error interrupt");
        wr(dbic_pkg::ERR_CLR, 32'h2);
        wr(dbic_pkg::LINK_CFG, 32'h102);
        seen = 1'b0;
        fork
            pulse_err(3);
            repeat (9) @(negedge sys_clk) seen |= pw_valid;
        join
        chk({30'h0, seen, pw_port[0]}, 32'h3, "port write");
        rd(dbic_pkg::ERR_STAT, 32'h0);
        repeat (3) far.send_sym(1'b1);
        far.send_sym(1'b0);
        repeat (3) far.send_sym(1'b1);
        chk({31'h0, link_reset}, 32'h0, "early reset");
        far.send_sym(1'b1);
        chk({30'h0, link_reset, int_critical}, 32'h3, "link reset");
        rd(dbic_pkg::LINK_CFG, 32'h10);
        rd(dbic_pkg::CRIT_STAT, 32'h1);
        wr(dbic_pkg::CRIT_CLR, 32'h1);
        rd(dbic_pkg::CRIT_STAT, 32'h0);
        summarize();
    end
endmodule
bind dbic_top dbic_top_chk chk_i (.*);
